// ### ioc_pkg.sv
`default_nettype none
package ioc_pkg;
  localparam int SAMPLE_W = 14;
  localparam int CH_NUM = 2;
  localparam int CH_IDX_W = 1;
  localparam int CORE_NUM = 4;
  localparam int CORE_IDX_W = 2;
  localparam int SPI_ADDR_W = 15;
  localparam logic [4:0] SPI_ADDR_LAST = 5'h000f;
  localparam logic [4:0] SPI_DATA_LAST = 5'h0017;
  localparam logic [4:0] SPI_DATA_FIRST = 5'h0010;
  localparam logic [2:0] SPI_PIN_IDLE = 3'h4;
  localparam logic [14:0] ADDR_PAGE0 = 15'h4001;
  localparam logic [14:0] ADDR_PAGE1 = 15'h4002;
  localparam logic [14:0] ADDR_PAGE_CH = 15'h4003;
  localparam logic [14:0] ADDR_PAGE_BLK = 15'h4004;
  localparam logic [14:0] ADDR_CTRL = 15'h6068;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PAGE_BLK_CORR = 8'h61;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] CTRL_FREEZE = 8'hc2;
  localparam logic [7:0] CTRL_BYPASS = 8'h46;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {
    IOC_RUN,
    IOC_FREEZE,
    IOC_BYPASS
  } ioc_mode_type;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } ioc_sample_type;

  function automatic ioc_mode_type ioc_mode_of(input logic [7:0] code);
    ioc_mode_type m;
    m = IOC_RUN;
    if (code == CTRL_FREEZE) begin
      m = IOC_FREEZE;
    end else if (code == CTRL_BYPASS) begin
      m = IOC_BYPASS;
    end
    return m;
  endfunction
endpackage
`default_nettype wire

// ### ioc_offset_corrector.sv
// Notes on behaviour
// - Per channel, estimate offset of each of four cores and subtract its difference from the four-core mean.
// - Running correction nulls fs/4 and fs/2 static tones; dc is left in place.
// - Every valid sample in run mode updates the estimate; real tones there are suppressed too.
// - Bypass applies no correction; samples pass through unaltered.
// - Freeze stops estimate updates and keeps applying the last estimate.
// - Idle channel is detected when input stays near zero for a while.
// - C2h written to 6068h freezes the selected channel's corrector.
// - 46h written to 6068h bypasses the selected channel's corrector.
`timescale 1ns/1ps
`default_nettype none
module ioc_offset_corrector
  import ioc_pkg::*;
#(
  parameter int FRAC_W      = 8,
  parameter int AVG_SHIFT   = 10,
  parameter int IDLE_THRESH = 16,
  parameter int IDLE_COUNT  = 256
) (
  // Clock and reset
  input  wire logic                        ref_clk_in,
  input  wire logic                        rstn_in,
  // Serial register port
  input  wire logic                        spi_sen_n_in,
  input  wire logic                        spi_sclk_in,
  input  wire logic                        spi_sdi_in,
  output var  logic                        spi_sdo_out,
  // Sample streams
  input  wire ioc_sample_type [CH_NUM-1:0] samp_in,
  output var  ioc_sample_type [CH_NUM-1:0] samp_out,
  // Channel state
  output var  logic [CH_NUM-1:0]           idle_out
);

  localparam int ACC_W = SAMPLE_W + FRAC_W + 2;
  localparam int DIF_W = SAMPLE_W + 3;

  // Pin synchronisers
  logic [2:0] pins;
  logic [2:0] sync_reg [3];
  logic [2:0] lvl_reg;

  assign pins = {spi_sen_n_in, spi_sclk_in, spi_sdi_in};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
        sync_reg[i] <= {3{SPI_PIN_IDLE[i]}};
        lvl_reg[i]  <= SPI_PIN_IDLE[i];
      end else begin
        sync_reg[i] <= {sync_reg[i][1:0], pins[i]};
        if (sync_reg[i][1] == sync_reg[i][2]) begin
          lvl_reg[i] <= sync_reg[i][2];
        end
      end
    end
  end

  // Serial frame engine
  logic                  sen_n;
  logic                  sclk;
  logic                  sdi;
  logic                  sclk_prev_reg;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic [4:0]            bit_cnt_reg;
  logic [23:0]           shift_reg;
  logic [SPI_ADDR_W-1:0] addr_reg;
  logic                  rd_reg;
  logic                  rd_load_reg;
  logic [7:0]            rd_shift_reg;
  logic                  wr_en_reg;
  logic [7:0]            wr_data_reg;
  logic                  addr_done;
  logic                  data_done;

  assign sen_n     = lvl_reg[2];
  assign sclk      = lvl_reg[1];
  assign sdi       = lvl_reg[0];
  assign sclk_rise = !sen_n && sclk && !sclk_prev_reg;
  assign sclk_fall = !sen_n && !sclk && sclk_prev_reg;
  assign addr_done = sclk_rise && (bit_cnt_reg == SPI_ADDR_LAST);
  assign data_done = sclk_rise && (bit_cnt_reg == SPI_DATA_LAST);

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      sclk_prev_reg <= 1'b0;
      bit_cnt_reg   <= '0;
      shift_reg     <= '0;
      addr_reg      <= '0;
      rd_reg        <= 1'b0;
      rd_load_reg   <= 1'b0;
      wr_en_reg     <= 1'b0;
      wr_data_reg   <= '0;
    end else begin
      sclk_prev_reg <= sclk;
      rd_load_reg   <= addr_done && shift_reg[14];
      wr_en_reg     <= data_done && !rd_reg;
      if (sen_n) begin
        bit_cnt_reg <= '0;
      end else if (sclk_rise) begin
        shift_reg   <= {shift_reg[22:0], sdi};
        bit_cnt_reg <= bit_cnt_reg + 5'h0001;
      end
      if (addr_done) begin
        addr_reg <= {shift_reg[13:0], sdi};
        rd_reg   <= shift_reg[14];
      end
      if (data_done) begin
        wr_data_reg <= {shift_reg[6:0], sdi};
      end
    end
  end

  // Paged register file
  logic [7:0]        page0_reg;
  logic [7:0]        page1_reg;
  logic [7:0]        page_ch_reg;
  logic [7:0]        page_blk_reg;
  logic [7:0]        ctrl_reg [CH_NUM];
  logic              page_ok;
  logic [CH_IDX_W-1:0] sel_ch;
  logic              ctrl_wr;
  logic [7:0]        ctrl_rd;
  logic [7:0]        rd_data;

  assign page_ok = (page0_reg == PAGE_ZERO) && (page1_reg == PAGE_ZERO)
                   && (page_blk_reg == PAGE_BLK_CORR)
                   && (page_ch_reg < 8'(CH_NUM));
  assign sel_ch  = page_ch_reg[CH_IDX_W-1:0];
  assign ctrl_wr = wr_en_reg && (addr_reg == ADDR_CTRL) && page_ok;
  assign ctrl_rd = page_ok ? ctrl_reg[sel_ch] : 8'h00;
  assign rd_data = (addr_reg == ADDR_PAGE0)    ? page0_reg :
                   (addr_reg == ADDR_PAGE1)    ? page1_reg :
                   (addr_reg == ADDR_PAGE_CH)  ? page_ch_reg :
                   (addr_reg == ADDR_PAGE_BLK) ? page_blk_reg :
                   (addr_reg == ADDR_CTRL)     ? ctrl_rd : 8'h00;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      page0_reg    <= PAGE_RESET;
      page1_reg    <= PAGE_RESET;
      page_ch_reg  <= PAGE_RESET;
      page_blk_reg <= PAGE_RESET;
    end else if (wr_en_reg) begin
      if (addr_reg == ADDR_PAGE0) begin
        page0_reg <= wr_data_reg;
      end
      if (addr_reg == ADDR_PAGE1) begin
        page1_reg <= wr_data_reg;
      end
      if (addr_reg == ADDR_PAGE_CH) begin
        page_ch_reg <= wr_data_reg;
      end
      if (addr_reg == ADDR_PAGE_BLK) begin
        page_blk_reg <= wr_data_reg;
      end
    end
  end

  // Read data return
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rd_shift_reg <= '0;
      spi_sdo_out  <= 1'b0;
    end else if (rd_load_reg) begin
      rd_shift_reg <= rd_data;
    end else if (sclk_fall && rd_reg && (bit_cnt_reg >= SPI_DATA_FIRST) && (bit_cnt_reg <= SPI_DATA_LAST)) begin
      spi_sdo_out  <= rd_shift_reg[7];
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
    end
  end

  // Per channel corrector
  for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
    ioc_mode_type                mode;
    logic [CORE_IDX_W-1:0]       core_reg;
    logic signed [ACC_W-1:0]     est_reg [CORE_NUM];
    logic signed [ACC_W-1:0]     est_sum;
    logic signed [ACC_W-1:0]     est_mean;
    logic signed [ACC_W-1:0]     x_fix;
    logic signed [ACC_W-1:0]     est_step;
    logic signed [ACC_W-1:0]     corr_fix;
    logic signed [DIF_W-1:0]     corr;
    logic signed [DIF_W-1:0]     y_wide;
    logic signed [SAMPLE_W-1:0]  x;
    logic signed [SAMPLE_W-1:0]  y_sat;
    logic [SAMPLE_W-1:0]         x_mag;
    logic [15:0]                 idle_cnt_reg;
    logic                        quiet;
    logic                        upd;

    assign mode     = ioc_mode_of(ctrl_reg[c]);
    assign x        = samp_in[c].data;
    assign x_fix    = ACC_W'(x) <<< FRAC_W;
    assign est_step = (x_fix - est_reg[core_reg]) >>> AVG_SHIFT;
    assign upd      = samp_in[c].valid && (mode == IOC_RUN);
    assign est_mean = est_sum >>> CORE_IDX_W;
    assign corr_fix = (est_reg[core_reg] - est_mean) >>> FRAC_W;
    assign corr     = corr_fix[DIF_W-1:0];
    assign y_wide   = DIF_W'(x) - corr;
    assign y_sat    = (y_wide > DIF_W'(2 ** (SAMPLE_W - 1) - 1)) ?
                      SAMPLE_W'(2 ** (SAMPLE_W - 1) - 1) :
                      (y_wide < -DIF_W'(2 ** (SAMPLE_W - 1))) ?
                      SAMPLE_W'(-(2 ** (SAMPLE_W - 1))) : y_wide[SAMPLE_W-1:0];
    assign x_mag    = x[SAMPLE_W-1] ? SAMPLE_W'(-x) : x;
    assign quiet    = x_mag <= SAMPLE_W'(IDLE_THRESH);

    always_comb begin
      est_sum = '0;
      for (int k = 0; k < CORE_NUM; k++) begin
        est_sum = est_sum + est_reg[k];
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
        ctrl_reg[c] <= CTRL_RESET;
      end else if (ctrl_wr && (sel_ch == CH_IDX_W'(c))) begin
        ctrl_reg[c] <= wr_data_reg;
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
        core_reg <= '0;
        for (int k = 0; k < CORE_NUM; k++) begin
          est_reg[k] <= '0;
        end
      end else if (samp_in[c].valid) begin
        core_reg <= core_reg + 1'b1;
        if (upd) begin
          est_reg[core_reg] <= est_reg[core_reg] + est_step;
        end
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
        samp_out[c] <= '0;
      end else begin
        samp_out[c].valid <= samp_in[c].valid;
        if (mode == IOC_BYPASS) begin
          samp_out[c].data <= samp_in[c].data;
        end else begin
          samp_out[c].data <= y_sat;
        end
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
        idle_cnt_reg <= '0;
        idle_out[c]  <= 1'b0;
      end else if (samp_in[c].valid) begin
        if (!quiet) begin
          idle_cnt_reg <= '0;
          idle_out[c]  <= 1'b0;
        end else if (idle_cnt_reg < 16'(IDLE_COUNT - 1)) begin
          idle_cnt_reg <= idle_cnt_reg + 16'h0001;
        end else begin
          idle_out[c] <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### ioc_offset_corrector_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ioc_offset_corrector_chk
  import ioc_pkg::*;
#(
  parameter int IDLE_THRESH = 16,
  parameter int IDLE_COUNT  = 256
) (
  // Clock and reset
  input wire logic                        ref_clk_in,
  input wire logic                        rstn_in,
  // Serial port
  input wire logic                        spi_sen_n_in,
  input wire logic                        spi_sdo_out,
  // Samples
  input wire ioc_sample_type [CH_NUM-1:0] samp_in,
  input wire ioc_sample_type [CH_NUM-1:0] samp_out,
  input wire logic [CH_NUM-1:0]           idle_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [31:0] q0_reg;
  wire logic   loud0 = samp_in[0].valid && ($signed(samp_in[0].data) > IDLE_THRESH
                       || $signed(samp_in[0].data) < -IDLE_THRESH);
  wire logic   loud1 = samp_in[1].valid && ($signed(samp_in[1].data) > IDLE_THRESH
                       || $signed(samp_in[1].data) < -IDLE_THRESH);
  // Quiet samples since the last loud one
  always_ff @(posedge ref_clk_in) begin
    q0_reg <= (!rstn_in || loud0) ? 32'h0000_0000 : q0_reg + 32'(samp_in[0].valid);
  end
  property p_rst; $rose(rstn_in) |-> samp_out == '0 && idle_out == '0 && !spi_sdo_out; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_v0; $past(rstn_in) |-> samp_out[0].valid == $past(samp_in[0].valid); endproperty
  a_v0: assert property (p_v0) else $error("ch0 valid lost");
  property p_v1; $past(rstn_in) |-> samp_out[1].valid == $past(samp_in[1].valid); endproperty
  a_v1: assert property (p_v1) else $error("ch1 valid lost");
  property p_rise0; $rose(idle_out[0]) |-> q0_reg >= IDLE_COUNT; endproperty
  a_rise0: assert property (p_rise0) else $error("idle too early");
  property p_set0; q0_reg >= IDLE_COUNT && !loud0 |-> ##[0:1] idle_out[0]; endproperty
  a_set0: assert property (p_set0) else $error("idle not set");
  property p_loud0; loud0 |=> !idle_out[0]; endproperty
  a_loud0: assert property (p_loud0) else $error("ch0 idle kept");
  property p_loud1; loud1 |=> !idle_out[1]; endproperty
  a_loud1: assert property (p_loud1) else $error("ch1 idle kept");
  property p_sdo; spi_sen_n_in [*8] |-> $stable(spi_sdo_out); endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved between frames");
  c_idle: cover property ($rose(idle_out[0]));
  c_loud: cover property (loud1);
  c_frame: cover property ($fell(spi_sen_n_in));
endmodule
bind ioc_offset_corrector ioc_offset_corrector_chk #(.IDLE_THRESH(IDLE_THRESH), .IDLE_COUNT(IDLE_COUNT)) chk_inst (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .spi_sen_n_in(spi_sen_n_in), .spi_sdo_out(spi_sdo_out),
  .samp_in(samp_in), .samp_out(samp_out), .idle_out(idle_out));
`default_nettype wire

// ### test_interleave_offset_corrector.sv
`timescale 1ns/1ps
`default_nettype none
module test_interleave_offset_corrector
  import ioc_pkg::*;
();
  logic                        clk;
  logic                        rstn;
  logic                        sen_n;
  logic                        sclk;
  logic                        sdi;
  logic                        sdo;
  logic [7:0]                  rdat;
  ioc_sample_type [CH_NUM-1:0] sin;
  ioc_sample_type [CH_NUM-1:0] sout;
  logic [1:0]                  idle;
  int                          num_errors;
  int                          compares;
  int                          k;
  int                          c;
  int                          o[4] = '{8, -8, 4, -4};

  ioc_offset_corrector #(.FRAC_W(8), .AVG_SHIFT(2), .IDLE_THRESH(16), .IDLE_COUNT(8)) ioc_offset_corrector_inst (
    .ref_clk_in(clk), .rstn_in(rstn), .spi_sen_n_in(sen_n), .spi_sclk_in(sclk), .spi_sdi_in(sdi),
    .spi_sdo_out(sdo), .samp_in(sin), .samp_out(sout), .idle_out(idle));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic spi_wr(input logic [14:0] a, input logic [7:0] d);
    logic [23:0] f;
    f = {1'b0, a, d};
    sen_n = 1'b0;
    cyc(4);
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      cyc(4);
      sclk = 1'b1;
      cyc(4);
      sclk = 1'b0;
    end
    cyc(4);
    sen_n = 1'b1;
    cyc(12);
  endtask

  task automatic spi_rd(input logic [14:0] a, output logic [7:0] r);
    logic [23:0] f;
    f = {1'b1, a, 8'h00};
    r = 8'h00;
    sen_n = 1'b0;
    cyc(4);
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      cyc(4);
      sclk = 1'b1;
      cyc(4);
      if (i < 8) begin
        r[i] = sdo;
      end
      sclk = 1'b0;
    end
    cyc(4);
    sen_n = 1'b1;
    cyc(12);
  endtask

  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: register read %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk(input logic [13:0] g, input int e);
    compares++;
    if ($isunknown(g) || $signed(g) > e + 1 || $signed(g) < e - 1) begin
      num_errors++;
      $display("ERROR %0t: sample %0d expected %0d", $time, $signed(g), e);
    end
  endtask

  task automatic chk_idle(input logic [1:0] e);
    compares++;
    if (idle !== e) begin
      num_errors++;
      $display("ERROR %0t: idle %b expected %b", $time, idle, e);
    end
  endtask

  // Per channel: input c + s*o[core], expected c + e*o[core]
  task automatic feed(input int n, ca, sa, ea, cb, sb, eb);
    logic v;
    int   pk;
    for (int i = 0; i < n; i++) begin
      v = ($urandom % 4) != 0;
      sin[0] = '{v, 14'(ca + sa * o[k])};
      sin[1] = '{v, 14'(cb + sb * o[k])};
      pk = k;
      if (v) k = (k + 1) % 4;
      cyc(1);
      if (v && i >= n - 12) begin
        chk(sout[0].data, ca + ea * o[pk]);
        chk(sout[1].data, cb + eb * o[pk]);
      end
    end
    sin = '0;
  endtask

  task automatic end_sim;
    $display("Errors: %0d Compares: %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    sen_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    sin = '0;
    k = 0;
    num_errors = 0;
    compares = 0;
    c = $urandom(31);
    cyc(4);
    rstn = 1'b1;
    cyc(4);
    chk_idle(2'b00);
    spi_wr(ADDR_PAGE0, PAGE_ZERO);
    spi_wr(ADDR_PAGE1, PAGE_ZERO);
    spi_wr(ADDR_PAGE_CH, PAGE_ZERO);
    spi_wr(ADDR_PAGE_BLK, PAGE_BLK_CORR);
    feed(16400, 0, 1, 0, 0, 1, 0);
    chk_idle(2'b11);
    spi_wr(ADDR_CTRL, CTRL_FREEZE);
    spi_rd(ADDR_CTRL, rdat);
    chk_reg(rdat, CTRL_FREEZE);
    feed(400, 0, 0, -1, 0, 0, 0);
    chk_idle(2'b11);
    spi_wr(ADDR_PAGE_CH, 8'h01);
    spi_wr(ADDR_CTRL, CTRL_BYPASS);
    spi_rd(ADDR_CTRL, rdat);
    chk_reg(rdat, CTRL_BYPASS);
    c = $urandom % 256 + 100;
    feed(100, c, 1, 0, c, 1, 1);
    spi_wr(ADDR_PAGE_BLK, PAGE_ZERO);
    spi_wr(ADDR_CTRL, CTRL_RESET);
    spi_rd(ADDR_CTRL, rdat);
    chk_reg(rdat, 8'h00);
    feed(100, c, 1, 0, c, 1, 1);
    spi_wr(ADDR_PAGE_BLK, PAGE_BLK_CORR);
    spi_wr(ADDR_CTRL, CTRL_RESET);
    spi_rd(ADDR_CTRL, rdat);
    chk_reg(rdat, CTRL_RESET);
    feed(400, c, 1, 0, c, 1, 0);
    end_sim;
  end
endmodule
`default_nettype wire
